// ==== hw/owp_pkg.sv ====
// Constants, state codes and pin bundle for the word programming sequencer
package owp_pkg;

	localparam int CLK_PERIOD_NS   = 25;
	localparam int PULSE_NOM_US    = 100;
	localparam int PULSE_MIN_US    = 95;
	localparam int PULSE_MAX_US    = 105;
	localparam int SETUP_US        = 2;
	localparam int HOLD_US         = 2;
	localparam int SUPPLY_SETUP_US = 2;
	localparam int OE_VALID_NS     = 150;
	localparam int RELEASE_NS      = 130;

	localparam int PULSE_CYC   = (PULSE_NOM_US * 1000) / CLK_PERIOD_NS;
	localparam int PULSE_MIN_C = (PULSE_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PULSE_MAX_C = (PULSE_MAX_US * 1000) / CLK_PERIOD_NS;
	localparam int SETUP_CYC   = (SETUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYC    = (HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SUPPLY_CYC  = (SUPPLY_SETUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYNC_CYC    = 2;
	localparam int OE_CYC      = (OE_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_CYC;
	localparam int RELEASE_CYC = (RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam int ADDR_W       = 16;
	localparam int DATA_W       = 16;
	localparam int TIMER_W      = 13;
	localparam int RETRY_W      = 4;
	localparam logic [ADDR_W-1:0]  LAST_ADDR   = 16'hffff;
	localparam logic [RETRY_W-1:0] RETRY_LIMIT = 4'ha;

	typedef enum logic [8:0] {
		ST_IDLE    = 9'h001,
		ST_SUPPLY  = 9'h002,
		ST_SETUP   = 9'h004,
		ST_PULSE   = 9'h008,
		ST_HOLD    = 9'h010,
		ST_READ    = 9'h020,
		ST_RELEASE = 9'h040,
		ST_LOWER   = 9'h080,
		ST_DONE    = 9'h100
	} owp_state_type;

	typedef enum logic [3:0] {
		PH_FIRST  = 4'h1,
		PH_VERIFY = 4'h2,
		PH_FINAL  = 4'h4,
		PH_ID     = 4'h8
	} owp_phase_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data_out;
		logic              data_oe;
		logic              chip_enable_n;
		logic              output_enable_n;
		logic              program_strobe_n;
		logic              id_entry_address_line;
		logic              vcc_raise;
		logic              vpp_raise;
	} owp_pins_type;

endpackage

// ==== hw/owp_sequencer.sv ====
// Programmer-side sequencer: rapid program/verify algorithm and id read
`timescale 1ns/100ps
module owp_sequencer
	import owp_pkg::*;
(
	input  wire logic                sys_clk,
	input  wire logic                rstn,
	input  wire logic                start_program,
	input  wire logic                start_id,
	input  wire logic                id_select,
	input  wire logic [DATA_W-1:0]   src_data,
	output logic [ADDR_W-1:0]        src_addr,
	input  wire logic [DATA_W-1:0]   mem_data_in,
	output owp_pins_type             pins,
	output logic                     busy,
	output logic                     done,
	output logic                     pass,
	output logic                     fail,
	output logic [ADDR_W-1:0]        fail_addr,
	output logic [DATA_W-1:0]        id_word
);

	////////////////////////////////////////////////////////////////////////
	// Data pin synchroniser; the device is not on our clock

	logic [DATA_W-1:0] data_meta;
	logic [DATA_W-1:0] data_sync;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			data_meta <= '0;
			data_sync <= '0;
		end else begin
			data_meta <= mem_data_in;
			data_sync <= data_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer

	function automatic logic [TIMER_W-1:0] cycles(input int n);
		cycles = TIMER_W'(n - 1);
	endfunction

	owp_state_type        state, next_state;
	owp_phase_type        phase, next_phase;
	logic [TIMER_W-1:0]   timer, next_timer;
	logic [RETRY_W-1:0]   retries, next_retries;
	logic                 mismatch, next_mismatch;
	owp_pins_type         next_pins;
	logic                 next_busy, next_done, next_pass, next_fail;
	logic [ADDR_W-1:0]    next_src_addr, next_fail_addr;
	logic [DATA_W-1:0]    next_id_word;

	always_comb begin
		next_state     = state;
		next_phase     = phase;
		next_timer     = (timer != '0) ? timer - 1'b1 : timer;
		next_retries   = retries;
		next_mismatch  = mismatch;
		next_pins      = pins;
		next_busy      = busy;
		next_done      = 1'b0;
		next_pass      = pass;
		next_fail      = fail;
		next_src_addr  = src_addr;
		next_fail_addr = fail_addr;
		next_id_word   = id_word;
		case (state)
			ST_IDLE: begin
				next_pins.data_oe          = 1'b0;
				next_pins.chip_enable_n    = 1'b1;
				next_pins.output_enable_n  = 1'b1;
				next_pins.program_strobe_n = 1'b1;
				if (start_program) begin
					next_phase              = PH_FIRST;
					next_src_addr           = '0;
					next_pins.addr          = '0;
					next_pins.vcc_raise     = 1'b1;
					next_pins.vpp_raise     = 1'b1;
					next_retries            = '0;
					next_busy               = 1'b1;
					next_pass               = 1'b0;
					next_fail               = 1'b0;
					next_timer              = cycles(SUPPLY_CYC);
					next_state              = ST_SUPPLY;
				end else if (start_id) begin
					next_phase                      = PH_ID;
					next_pins.addr                  = {{(ADDR_W-1){1'b0}}, id_select};
					next_pins.id_entry_address_line = 1'b1;
					next_pins.chip_enable_n         = 1'b0;
					next_busy                       = 1'b1;
					next_timer                      = cycles(SETUP_CYC);
					next_state                      = ST_SUPPLY;
				end
			end
			ST_SUPPLY: begin
				// Supplies and id voltage settle before any pin activity counts
				if (timer == '0) begin
					next_pins.chip_enable_n = 1'b0;
					if (phase == PH_ID) begin
						next_pins.output_enable_n = 1'b0;
						next_timer                = cycles(OE_CYC);
						next_state                = ST_READ;
					end else begin
						next_pins.data_out = src_data;
						next_pins.data_oe  = 1'b1;
						next_timer         = cycles(SETUP_CYC);
						next_state         = ST_SETUP;
					end
				end
			end
			ST_SETUP: begin
				next_pins.data_out = src_data;
				if (timer == '0) begin
					next_pins.program_strobe_n = 1'b0;
					next_timer                 = cycles(PULSE_CYC);
					next_state                 = ST_PULSE;
				end
			end
			ST_PULSE: begin
				if (timer == '0) begin
					next_pins.program_strobe_n = 1'b1;
					next_timer                 = cycles(HOLD_CYC);
					next_state                 = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (timer == '0) begin
					if (phase == PH_FIRST && pins.addr != LAST_ADDR) begin
						next_pins.addr = pins.addr + 1'b1;
						next_src_addr  = pins.addr + 1'b1;
						next_timer     = cycles(SETUP_CYC);
						next_state     = ST_SETUP;
					end else begin
						if (phase == PH_FIRST) begin
							next_phase     = PH_VERIFY;
							next_pins.addr = '0;
							next_src_addr  = '0;
							next_retries   = '0;
						end
						next_pins.data_oe         = 1'b0;
						next_pins.output_enable_n = 1'b0;
						next_timer                = cycles(OE_CYC);
						next_state                = ST_READ;
					end
				end
			end
			ST_READ: begin
				if (timer == '0) begin
					next_mismatch             = (data_sync != src_data);
					next_id_word              = (phase == PH_ID) ? data_sync : id_word;
					next_pins.output_enable_n = 1'b1;
					next_timer                = cycles(RELEASE_CYC);
					next_state                = ST_RELEASE;
				end
			end
			ST_RELEASE: begin
				// Bus stays undriven until the device has surely floated
				if (timer == '0) begin
					if (phase == PH_ID) begin
						next_pins.id_entry_address_line = 1'b0;
						next_pins.chip_enable_n         = 1'b1;
						next_pins.addr                  = '0;
						next_state                      = ST_DONE;
					end else if (mismatch && phase == PH_VERIFY && retries != RETRY_LIMIT) begin
						next_retries       = retries + 1'b1;
						next_pins.data_out = src_data;
						next_pins.data_oe  = 1'b1;
						next_timer         = cycles(SETUP_CYC);
						next_state         = ST_SETUP;
					end else if (mismatch) begin
						next_fail                 = 1'b1;
						next_fail_addr            = pins.addr;
						next_pins.vcc_raise       = 1'b0;
						next_pins.vpp_raise       = 1'b0;
						next_pins.chip_enable_n   = 1'b1;
						next_state                = ST_DONE;
					end else if (pins.addr != LAST_ADDR) begin
						next_pins.addr            = pins.addr + 1'b1;
						next_src_addr             = pins.addr + 1'b1;
						next_retries              = '0;
						next_timer                = cycles(SETUP_CYC);
						next_state                = ST_LOWER;
					end else if (phase == PH_VERIFY) begin
						next_phase                = PH_FINAL;
						next_pins.addr            = '0;
						next_src_addr             = '0;
						next_pins.vcc_raise       = 1'b0;
						next_pins.vpp_raise       = 1'b0;
						next_timer                = cycles(SUPPLY_CYC);
						next_state                = ST_LOWER;
					end else begin
						next_pass                 = 1'b1;
						next_pins.chip_enable_n   = 1'b1;
						next_state                = ST_DONE;
					end
				end
			end
			ST_LOWER: begin
				// Address settle or supply fall before the next read
				if (timer == '0) begin
					next_pins.output_enable_n = 1'b0;
					next_timer                = cycles(OE_CYC);
					next_state                = ST_READ;
				end
			end
			ST_DONE: begin
				next_busy  = 1'b0;
				next_done  = 1'b1;
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state     <= ST_IDLE;
			phase     <= PH_FIRST;
			timer     <= '0;
			retries   <= '0;
			mismatch  <= 1'b0;
			pins      <= '{addr: '0, data_out: '0, data_oe: 1'b0, chip_enable_n: 1'b1,
				output_enable_n: 1'b1, program_strobe_n: 1'b1, id_entry_address_line: 1'b0,
				vcc_raise: 1'b0, vpp_raise: 1'b0};
			busy      <= 1'b0;
			done      <= 1'b0;
			pass      <= 1'b0;
			fail      <= 1'b0;
			src_addr  <= '0;
			fail_addr <= '0;
			id_word   <= '0;
		end else begin
			state     <= next_state;
			phase     <= next_phase;
			timer     <= next_timer;
			retries   <= next_retries;
			mismatch  <= next_mismatch;
			pins      <= next_pins;
			busy      <= next_busy;
			done      <= next_done;
			pass      <= next_pass;
			fail      <= next_fail;
			src_addr  <= next_src_addr;
			fail_addr <= next_fail_addr;
			id_word   <= next_id_word;
		end
	end

endmodule // owp_sequencer

// ==== tb/owp_sequencer_asserts.sv ====
// Concurrent checks on the sequencer pins and run handshake
`timescale 1ns/100ps
module owp_sequencer_asserts
	import owp_pkg::*;
(
	input wire logic         sys_clk,
	input wire logic         rstn,
	input wire logic         start_program,
	input wire logic         start_id,
	input wire logic         id_select,
	input wire owp_pins_type pins,
	input wire logic         busy,
	input wire logic         done,
	input wire logic         fail,
	input wire logic         pass
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	////////////////////////////////////////////////////////////////////////////////
	// Strobe-low length and oe-high age, oe age saturates
	logic [12:0] low_cnt, next_low_cnt;
	logic [3:0]  oe_hi_cnt, next_oe_hi_cnt;
	always_comb begin
		next_low_cnt   = pins.program_strobe_n ? 13'h0000 : low_cnt + 13'h0001;
		next_oe_hi_cnt = !pins.output_enable_n ? 4'h0 : (oe_hi_cnt == 4'hf ? oe_hi_cnt : oe_hi_cnt + 4'h1);
	end
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			low_cnt   <= 13'h0000;
			oe_hi_cnt <= 4'h0;
		end else begin
			low_cnt   <= next_low_cnt;
			oe_hi_cnt <= next_oe_hi_cnt;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	sequence s_prog_take; start_program && !busy && !done; endsequence
	sequence s_id_take; start_id && !start_program && !busy && !done; endsequence
	sequence s_id_enter; busy && pins.id_entry_address_line && !pins.chip_enable_n; endsequence
	sequence s_id_wait; (pins.id_entry_address_line && pins.output_enable_n)[*8]; endsequence
	property p_prog_start; s_prog_take |=> busy && pins.vcc_raise && pins.vpp_raise && pins.addr == 16'h0000; endproperty
	property p_id_start; s_id_take |=> s_id_enter and pins.addr == {15'h0000, $past(id_select)} ##1 s_id_wait; endproperty
	property p_strobe_ctl; !pins.program_strobe_n |-> !pins.chip_enable_n && pins.output_enable_n; endproperty
	property p_strobe_stable; !pins.program_strobe_n && $past(!pins.program_strobe_n) |->
		$stable(pins.addr) && $stable(pins.data_out) && pins.data_oe; endproperty
	property p_pulse_len; $rose(pins.program_strobe_n) |-> low_cnt >= PULSE_MIN_C && low_cnt <= PULSE_MAX_C; endproperty
	property p_pulse_max; !pins.program_strobe_n |-> low_cnt < PULSE_MAX_C; endproperty
	property p_supply; !pins.program_strobe_n |-> pins.vcc_raise && pins.vpp_raise; endproperty
	property p_release; $rose(pins.data_oe) |-> pins.output_enable_n && oe_hi_cnt >= RELEASE_CYC; endproperty
	property p_no_contend; !pins.output_enable_n |-> !pins.data_oe; endproperty
	property p_id_pins; pins.id_entry_address_line |-> pins.addr[15:1] == 15'h0000 && !pins.vpp_raise; endproperty
	property p_fail_stop; fail |-> pins.program_strobe_n; endproperty
	// Run end leaves the part deselected at normal supplies
	property p_done_safe; done |-> !busy && pins.chip_enable_n && !pins.vcc_raise && !pins.vpp_raise; endproperty
	property p_verdict; !(pass && fail); endproperty
	a_prog_start: assert property (p_prog_start) else $error("program start pins wrong");
	a_id_start: assert property (p_id_start) else $error("id entry pins wrong");
	a_strobe_ctl: assert property (p_strobe_ctl) else $error("strobe with bad enables");
	a_strobe_stable: assert property (p_strobe_stable) else $error("pins moved in pulse");
	a_pulse_len: assert property (p_pulse_len) else $error("pulse length out of range");
	a_pulse_max: assert property (p_pulse_max) else $error("pulse too long");
	a_supply: assert property (p_supply) else $error("pulse without raised supplies");
	a_release: assert property (p_release) else $error("data driven before release");
	a_no_contend: assert property (p_no_contend) else $error("data driven during read");
	a_id_pins: assert property (p_id_pins) else $error("id address wrong");
	a_fail_stop: assert property (p_fail_stop) else $error("pulse after failure");
	a_done_safe: assert property (p_done_safe) else $error("run ended with part still powered up");
	a_verdict: assert property (p_verdict) else $error("pass and fail both set");
endmodule // owp_sequencer_asserts

// ==== tb/owp_otp_model.sv ====
// Behavioural one-time-programmable memory on the sequencer pins
`timescale 1ns/100ps
module owp_otp_model
	import owp_pkg::*;
#(
	parameter logic [15:0] MAKER_WORD = 16'h3c5a, // Arbitrary value
	parameter logic [15:0] PART_WORD  = 16'h7e81  // Arbitrary value
)(
	input  wire owp_pins_type pins,
	output logic [DATA_W-1:0] q,
	output logic              q_oe,
	output logic [7:0]        viol_cnt,
	output logic [7:0]        rd_cnt
);
	logic [DATA_W-1:0] mem [0:65535];
	logic [DATA_W-1:0] word, held;
	int                pulse_cnt;
	realtime           t_fall;
	initial begin
		for (int i = 0; i < 65536; i++) mem[i] = 16'hffff;
		q_oe = 1'b0; viol_cnt = 8'h00; rd_cnt = 8'h00; pulse_cnt = 0; t_fall = 0.0; held = 16'h0000;
	end
	////////////////////////////////////////////////////////////////////////////////
	always @(negedge pins.program_strobe_n) begin
		t_fall = $realtime;
		if (pins.chip_enable_n || !pins.output_enable_n) viol_cnt++;
		if (!pins.vcc_raise || !pins.vpp_raise) viol_cnt++;
	end
	// Only in-range pulses store; bits can only be cleared
	always @(posedge pins.program_strobe_n) if (t_fall > 0.0) begin
		if ($realtime - t_fall < 95000.0 || $realtime - t_fall > 105000.0) viol_cnt++;
		else begin
			mem[pins.addr] = mem[pins.addr] & pins.data_out;
			pulse_cnt++;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	always @* word = !pins.id_entry_address_line ? mem[pins.addr] :
		(pins.addr[15:1] != 15'h0000 ? 16'hdead : (pins.addr[0] ? PART_WORD : MAKER_WORD));
	always @(negedge pins.output_enable_n) if (!pins.chip_enable_n) begin
		rd_cnt++;
		#20 q_oe = 1'b1;
	end
	always @(posedge pins.output_enable_n) #130 q_oe = 1'b0;
	always @(pins.data_oe or q_oe) if (pins.data_oe && q_oe) viol_cnt++;
	// Released lines show the inverse so a stale value never matches
	always @* if (q_oe) held = word;
	assign q = q_oe ? word : ~held;
endmodule // owp_otp_model

// ==== tb/tb_owp_sequencer.sv ====
// Self-checking bench: id reads, first-pass pulses, mid-run reset
`timescale 1ns/100ps
module tb_owp_sequencer;
	import owp_pkg::*;
	localparam logic [15:0] MAKER = 16'h3c5a; // Arbitrary value
	localparam logic [15:0] PART  = 16'h7e81; // Arbitrary value
	logic              sys_clk, rstn, start_program, start_id, id_select, busy, done, pass, fail, q_oe;
	logic [DATA_W-1:0] src_data, mem_data_in, q, id_word;
	logic [ADDR_W-1:0] src_addr, fail_addr;
	logic [7:0]        viol_cnt, rd_cnt;
	logic [DATA_W-1:0] src_tab [0:7];
	owp_pins_type      pins;
	int                error_cnt, n_tests, cyc, seed, n;
	logic [15:0]       exp_q [$];
	owp_sequencer u_owp_sequencer (.sys_clk(sys_clk), .rstn(rstn), .start_program(start_program),
		.start_id(start_id), .id_select(id_select), .src_data(src_data), .src_addr(src_addr),
		.mem_data_in(mem_data_in), .pins(pins), .busy(busy), .done(done), .pass(pass), .fail(fail),
		.fail_addr(fail_addr), .id_word(id_word));
	owp_otp_model #(.MAKER_WORD(MAKER), .PART_WORD(PART)) u_owp_otp_model (.pins(pins), .q(q), .q_oe(q_oe),
		.viol_cnt(viol_cnt), .rd_cnt(rd_cnt));
	assign mem_data_in = pins.data_oe ? pins.data_out : q;
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) src_data <= src_tab[src_addr[2:0]];
	// Whole run is about 13k cycles
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			give_verdict();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("errors=%0d tests=%0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic kick(input logic prog, input logic sel);
		@(posedge sys_clk);
		start_program <= prog; start_id <= !prog; id_select <= sel;
		@(posedge sys_clk);
		start_program <= 1'b0; start_id <= 1'b0;
		@(negedge sys_clk);
	endtask
	task automatic id_read(input logic sel);
		kick(1'b0, sel);
		exp_q.push_back(sel ? PART : MAKER);
		chk(busy, 1'b1);
		n = 0;
		while (done !== 1'b1 && n < 300) begin @(negedge sys_clk); n++; end
		chk(n < 300, 1'b1);
		chk({busy, pass, fail}, 3'b000);
		chk(id_word, exp_q.pop_front());
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 32'h45b6; error_cnt = 0; n_tests = 0; cyc = 0; src_data = 16'h0000;
		rstn = 1'b0; start_program = 1'b0; start_id = 1'b0; id_select = 1'b0;
		for (int i = 0; i < 8; i++) src_tab[i] = 16'($random(seed));
		repeat (20) @(posedge sys_clk);
		rstn <= 1'b1;
		@(negedge sys_clk);
		chk({pins.chip_enable_n, pins.output_enable_n, pins.program_strobe_n, pins.data_oe,
			pins.vcc_raise, pins.vpp_raise, busy, fail}, 8'he0);
		id_read(1'b0);
		id_read(1'b1);
		// Full array takes far too long; check first-pass pulses only
		kick(1'b1, 1'b0);
		chk({pins.vcc_raise, pins.vpp_raise, pins.addr}, {2'b11, 16'h0000});
		for (int k = 0; k < 3; k++) begin
			n = 0;
			while (pins.program_strobe_n !== 1'b0 && n < 400) begin @(negedge sys_clk); n++; end
			chk(pins.addr, k);
			chk(src_addr, k);
			chk(pins.data_out, src_tab[k]);
			n = 0;
			while (pins.program_strobe_n !== 1'b1 && n < 5000) begin @(negedge sys_clk); n++; end
			chk(n, PULSE_CYC);
			chk(u_owp_otp_model.mem[k], src_tab[k]);
		end
		chk(rd_cnt, 8'h02);
		chk(u_owp_otp_model.pulse_cnt, 3);
		chk({pass, fail, fail_addr}, 18'h00000);
		repeat (10) @(posedge sys_clk);
		rstn <= 1'b0;
		@(negedge sys_clk);
		chk({pins.program_strobe_n, pins.chip_enable_n, pins.vcc_raise, pins.vpp_raise, busy}, 5'b11000);
		@(posedge sys_clk);
		rstn <= 1'b1;
		id_read(1'b1);
		chk(viol_cnt, 8'h00);
		give_verdict();
	end
endmodule // tb_owp_sequencer
bind owp_sequencer owp_sequencer_asserts u_owp_sequencer_asserts (.sys_clk(sys_clk), .rstn(rstn),
	.start_program(start_program), .start_id(start_id), .id_select(id_select), .pins(pins),
	.busy(busy), .done(done), .fail(fail), .pass(pass));
